// ==== hw/mss_sequencer.sv ====
// Soft-start sequencer, channel detection and interleaved phase outputs
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] Reset holds every phase output three-state
// [R2] Reset release starts soft-start; outputs stay three-state until the clamp
// [R3] Supply drop returns outputs to three-state
// [R4] First 32 cycles: reference inhibited, three-state
// [R5] From cycle 33, clamp low ~150 cycles
// [R6] Then ramp duty from zero upward
// [R7] Reference rises gradually, paced by oscillator
// [R8] Power-ok held off until cycle 2048
// [R9] Up to four phases; phase 3, or phases 3 and 2, tied high are unused
// [R10] Active phases spaced 360 over count
// [R11] Higher error gives longer duty, uninverted
// [R12] Above-average channel current shortens pulse
// [R13] Disable pin low three-states all outputs
// [R14] Board ties unused upper outputs high
// [R15] Channel count latched once at reset release
// [R16] Each output is drive plus enable
module mss_sequencer (
    input  wire logic                                    clk_sys,
    input  wire logic                                    reset,
    input  wire logic                                    freq_select_disable_pin,
    input  wire logic [mss_pkg::PHASES-1:0]              phase_pin_in,
    input  wire logic [mss_pkg::DUTY_W-1:0]              error_level,
    input  wire logic [mss_pkg::PHASES*mss_pkg::DUTY_W-1:0] chan_current,
    input  wire logic                                    core_in_window,
    output logic [mss_pkg::PHASES-1:0]                   phase_out_r,
    output logic [mss_pkg::PHASES-1:0]                   phase_oe_r,
    output logic [mss_pkg::REF_W-1:0]                    ref_code_r,
    output logic                                         power_ok_flag_r,
    output logic [2:0]                                   active_count_r
);
    import mss_pkg::*;

    mss_state_type         state_r, state_nxt;   // Sequencer state
    logic [CNT_W-1:0]      cyc_r;                // Switching cycles since start
    logic [7:0]            tick_r;               // Position within one switching cycle
    logic [DUTY_W-1:0]     duty_lim_r;           // Soft-start duty ceiling
    logic                  dis_s1_r, dis_s2_r;   // Disable pin synchroniser
    logic [PHASES-1:0]     tie_s1_r, tie_s2_r;   // Phase pin readback synchroniser
    logic [PHASES-1:0]     unused_r;             // Latched unused-phase mask
    logic                  latch_pend_r;         // Count still to be captured
    logic [PHASES-1:0]     pwm_w;                // Raw per-phase PWM
    logic [PHASES-1:0]     drive_w, oe_w;        // Next pin drive and enable

    // Two-flop synchronisers for off-chip levels
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dis_s1_r <= 1'b0;
            dis_s2_r <= 1'b0;
            tie_s1_r <= '0;
            tie_s2_r <= '0;
        end else begin
            dis_s1_r <= freq_select_disable_pin;
            dis_s2_r <= dis_s1_r;
            tie_s1_r <= phase_pin_in;
            tie_s2_r <= tie_s1_r;
        end
    end

    // Pin low disables the converter outright
    wire logic disabled_w = ~dis_s2_r; // see [R13]

    // Wait past the synchroniser so the captured mask is settled
    wire logic capture_w = latch_pend_r && (tick_r == 8'h02);

    // Latch unused mask once after reset release; board ties top ones high
    // The third phase counts as unused only when the fourth is tied as well
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            unused_r     <= '0;
            latch_pend_r <= 1'b1;
        end else if (capture_w) begin
            unused_r     <= {tie_s2_r[3], tie_s2_r[3] & tie_s2_r[2], 2'b00}; // see [R9] [R14] [R15]
            latch_pend_r <= 1'b0;
        end
    end

    // Count of active channels from the mask
    function automatic logic [2:0] count_active(input logic [PHASES-1:0] unused);
        count_active = 3'(PHASES) - 3'(unused[3]) - 3'(unused[2]);
    endfunction : count_active

    wire logic [2:0] n_act_w = count_active(unused_r); // see [R9]

    // Switching cycle tick generator; the sawtooth is this counter
    wire logic cyc_end_w = (tick_r == SAW_MAX);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + 8'h01;
        end
    end

    // Sequence advances on cycle boundaries, except leaving MSS_OFF and falling back to it on disable
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MSS_OFF:      if (!latch_pend_r && !disabled_w) state_nxt = MSS_TRISTATE; // see [R2]
            MSS_TRISTATE: if (cyc_end_w && cyc_r == TRI_END - 12'h001) state_nxt = MSS_CLAMP; // see [R4] [R5]
            MSS_CLAMP:    if (cyc_end_w && cyc_r == CLAMP_END - 12'h001) state_nxt = MSS_RAMP; // see [R5]
            MSS_RAMP:     if (cyc_end_w && duty_lim_r == SAW_MAX) state_nxt = MSS_RUN;   // see [R6]
            MSS_RUN:      state_nxt = MSS_RUN;
            default:      state_nxt = MSS_OFF;
        endcase
        if (disabled_w) begin
            state_nxt = MSS_OFF; // see [R13]
        end
    end

    // State register; reset also models the supply falling away
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= MSS_OFF; // see [R1] [R3]
        end else begin
            state_r <= state_nxt;
        end
    end

    // Cycle counter saturates at the power-ok point
    always_ff @(posedge clk_sys) begin
        if (reset || state_r == MSS_OFF) begin
            cyc_r <= '0;
        end else if (cyc_end_w && cyc_r != PG_END) begin
            cyc_r <= cyc_r + 12'h001;
        end
    end

    // Duty ceiling climbs one step per cycle once ramping
    always_ff @(posedge clk_sys) begin
        if (reset || state_r == MSS_OFF || state_r == MSS_TRISTATE || state_r == MSS_CLAMP) begin
            duty_lim_r <= '0;
        end else if (cyc_end_w && duty_lim_r != SAW_MAX) begin
            duty_lim_r <= duty_lim_r + 8'h01; // see [R6]
        end
    end

    // Reference inhibited early, then stepped once per switching cycle
    always_ff @(posedge clk_sys) begin
        if (reset || state_r == MSS_OFF || state_r == MSS_TRISTATE) begin
            ref_code_r <= REF_RESET; // see [R4]
        end else if (cyc_end_w && ref_code_r != SAW_MAX) begin
            ref_code_r <= ref_code_r + 8'h01; // see [R7]
        end
    end

    // Average current of active channels only
    function automatic logic [DUTY_W-1:0] average(input logic [PHASES*DUTY_W-1:0] cur,
                                                 input logic [PHASES-1:0] unused,
                                                 input logic [2:0] n);
        logic [DUTY_W+1:0] sum;
        sum = '0;
        for (int i = 0; i < PHASES; i++) begin
            if (!unused[i]) begin
                sum = sum + (DUTY_W+2)'(cur[i*DUTY_W +: DUTY_W]);
            end
        end
        case (n)
            3'd4:    average = DUTY_W'(sum >> 2);
            // Widened first: three full-scale currents times 85 overflow ten bits
            3'd3:    average = DUTY_W'((18'(sum) * 18'd85) >> 8);
            default: average = DUTY_W'(sum >> 1);
        endcase
    endfunction : average

    wire logic [DUTY_W-1:0] avg_w = average(chan_current, unused_r, n_act_w); // see [R12]

    // Phase offset on the sawtooth: index times 256 over count
    function automatic logic [DUTY_W-1:0] phase_offset(input int idx, input logic [2:0] n);
        case (n)
            3'd4:    phase_offset = DUTY_W'(idx * 64);
            3'd3:    phase_offset = DUTY_W'(idx * 85);
            default: phase_offset = DUTY_W'(idx * 128);
        endcase
    endfunction : phase_offset

    wire logic running_w = (state_r == MSS_RAMP) || (state_r == MSS_RUN);

    // One comparator per phase on its own shifted sawtooth
    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_phase
            wire logic [DUTY_W-1:0] saw_w = DUTY_W'(tick_r + phase_offset(g, n_act_w)); // see [R10]
            mss_phase_pwm u_pwm (
                .clk_sys      (clk_sys),
                .reset        (reset),
                .run          (running_w && !unused_r[g]),
                .saw          (saw_w),
                .duty_limit   (duty_lim_r),
                .error_level  (error_level),
                .chan_current (chan_current[g*DUTY_W +: DUTY_W]),
                .avg_current  (avg_w),
                .pwm_r        (pwm_w[g])
            );
            // Unused phases never driven so the board tie stays readable
            assign oe_w[g]    = !unused_r[g] && (state_r == MSS_CLAMP || running_w); // see [R16]
            assign drive_w[g] = running_w ? pwm_w[g] : 1'b0; // see [R5]
        end
    endgenerate

    // Registered pin drive and enable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phase_out_r <= '0;
            phase_oe_r  <= '0; // see [R1]
        end else begin
            phase_out_r <= drive_w;
            phase_oe_r  <= oe_w; // see [R16]
        end
    end

    // Power-ok waits for the cycle count and the window monitor
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            power_ok_flag_r <= 1'b0;
            active_count_r  <= 3'd0;
        end else begin
            power_ok_flag_r <= (state_r == MSS_RUN || state_r == MSS_RAMP) &&
                               (cyc_r == PG_END) && core_in_window; // see [R8]
            // Held at zero until captured, so a shown count never changes
            active_count_r  <= latch_pend_r ? 3'd0 : n_act_w; // see [R15]
        end
    end
endmodule : mss_sequencer
`default_nettype wire

// ==== hw/mss_pkg.sv ====
// Package of constants and types for the multiphase soft-start sequencer
package mss_pkg;
    localparam int unsigned PHASES        = 4;      // Most phase channels supported
    localparam int unsigned CNT_W         = 12;     // Width of the soft-start cycle counter
    localparam int unsigned DUTY_W        = 8;      // Width of duty, error and current words
    localparam int unsigned REF_W         = 8;      // Width of the internal reference code
    localparam int unsigned TRI_CYCLES    = 32;     // Switching cycles held three-state
    localparam int unsigned CLAMP_CYCLES  = 150;    // Further cycles clamped low
    localparam int unsigned POWER_OK_FLAG_CYCLE   = 2048;   // First cycle at which power-ok may rise
    localparam int unsigned SW_CYCLE_CLKS = 256;    // System clocks per switching cycle
    localparam logic [CNT_W-1:0]  TRI_END   = 12'h020; // First clamp cycle count, one past the last three-state cycle
    localparam logic [CNT_W-1:0]  CLAMP_END = 12'h0b6; // TRI_END plus clamp length
    localparam logic [CNT_W-1:0]  PG_END    = 12'h800; // Power-ok release cycle count
    localparam logic [DUTY_W-1:0] SAW_MAX   = 8'hff;   // Top of the sawtooth
    localparam logic [REF_W-1:0]  REF_RESET = 8'h00;   // Reference code after reset
    // Sequencer states
    typedef enum logic [2:0] {
        MSS_OFF,
        MSS_TRISTATE,
        MSS_CLAMP,
        MSS_RAMP,
        MSS_RUN
    } mss_state_type;
endpackage : mss_pkg

// ==== hw/mss_phase_pwm.sv ====
// One phase channel: sawtooth comparator with current-balance trim
`timescale 1ns/10ps
`default_nettype none
module mss_phase_pwm (
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic                        run,
    input  wire logic [mss_pkg::DUTY_W-1:0]  saw,
    input  wire logic [mss_pkg::DUTY_W-1:0]  duty_limit,
    input  wire logic [mss_pkg::DUTY_W-1:0]  error_level,
    input  wire logic [mss_pkg::DUTY_W-1:0]  chan_current,
    input  wire logic [mss_pkg::DUTY_W-1:0]  avg_current,
    output logic                             pwm_r
);
    import mss_pkg::*;

    // Excess current above average, zero when at or below it
    wire logic [DUTY_W-1:0] excess_w = (chan_current > avg_current) ?
                                       DUTY_W'(chan_current - avg_current) : '0;
    // Higher error gives more duty, excess current trims it back
    wire logic [DUTY_W-1:0] trimmed_w = (error_level > excess_w) ?
                                        DUTY_W'(error_level - excess_w) : '0; // see [R11] [R12]
    // Soft-start ceiling caps the duty while ramping
    wire logic [DUTY_W-1:0] duty_w = (trimmed_w < duty_limit) ? trimmed_w : duty_limit; // see [R6]

    // High while sawtooth is below the duty, no inversion
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= run && (saw < duty_w); // see [R11]
        end
    end
endmodule : mss_phase_pwm
`default_nettype wire

// ==== sim/mss_sequencer_props.sv ====
// Checker of the soft-start sequencer port behaviour
`timescale 1ns/10ps
`default_nettype none
module mss_sequencer_props (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        freq_select_disable_pin,
    input wire logic [3:0]  phase_pin_in,
    input wire logic [7:0]  error_level,
    input wire logic [31:0] chan_current,
    input wire logic        core_in_window,
    input wire logic [3:0]  phase_out_r,
    input wire logic [3:0]  phase_oe_r,
    input wire logic [7:0]  ref_code_r,
    input wire logic        power_ok_flag_r,
    input wire logic [2:0]  active_count_r
);
    localparam int TRI_CLKS = 8192;    // 32 switching cycles of 256 clocks
    localparam int CLAMP_CLKS = 46592; // Three-state plus clamp, in clocks
    localparam int OK_CLKS = 524288;   // 2048 switching cycles
    int unsigned up_cnt_r;             // Clocks since reset release, saturating
    // Lower bound only: a disable restart makes the real times later, never earlier
    always_ff @(posedge clk_sys) begin
        if (reset)
            up_cnt_r <= 0;
        else if (up_cnt_r < 600000)
            up_cnt_r <= up_cnt_r + 1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Disable pin seen low long enough to pass the synchroniser
    sequence s_pin_low_held;
        !freq_select_disable_pin [*5];
    endsequence
    a_reset_tristate: assert property (disable iff (1'b0)
        reset |=> phase_oe_r == 4'h0 && !power_ok_flag_r) else $error("drive during reset");
    a_disable_tristate: assert property (s_pin_low_held |-> phase_oe_r == 4'h0)
        else $error("drive while disabled");
    a_early_drive: assert property ((phase_oe_r != 4'h0) |-> up_cnt_r > TRI_CLKS)
        else $error("drive inside three-state interval");
    a_clamp_low: assert property ((phase_oe_r != 4'h0 && up_cnt_r < CLAMP_CLKS)
        |-> phase_out_r == 4'h0) else $error("switching inside clamp interval");
    a_fourth_unused: assert property (phase_oe_r[3] |-> active_count_r == 3'd4)
        else $error("unused fourth phase driven");
    a_third_unused: assert property (phase_oe_r[2] |-> active_count_r >= 3'd3)
        else $error("unused third phase driven");
    a_count_fixed: assert property ((active_count_r != 3'd0)
        |=> $stable(active_count_r)) else $error("channel count changed");
    a_ok_late: assert property (power_ok_flag_r |-> up_cnt_r >= OK_CLKS)
        else $error("power ok too early");
    a_ok_window: assert property ($rose(power_ok_flag_r) |-> $past(core_in_window))
        else $error("power ok outside window");
    a_ref_steps: assert property ($changed(ref_code_r) |->
        ref_code_r == $past(ref_code_r) + 8'h01 || ref_code_r == 8'h00)
        else $error("reference jumped");
endmodule : mss_sequencer_props
bind mss_sequencer mss_sequencer_props u_props (
    .clk_sys(clk_sys), .reset(reset), .freq_select_disable_pin(freq_select_disable_pin),
    .phase_pin_in(phase_pin_in), .error_level(error_level), .chan_current(chan_current),
    .core_in_window(core_in_window), .phase_out_r(phase_out_r), .phase_oe_r(phase_oe_r),
    .ref_code_r(ref_code_r), .power_ok_flag_r(power_ok_flag_r),
    .active_count_r(active_count_r));
`default_nettype wire

// ==== sim/mss_gate_drv_model.sv ====
// Gate driver model for each phase, with board ties on unused pins
`timescale 1ns/10ps
`default_nettype none
module mss_gate_drv_model (
    input  wire logic [3:0] phase_out_r,
    input  wire logic [3:0] phase_oe_r,
    input  wire logic [3:0] tie_high,
    output logic      [3:0] pin_level,
    output logic      [3:0] upper_on,
    output logic      [3:0] lower_on
);
    // Board tie wins; a released pin sits at the driver's mid bias, read as low
    assign pin_level = tie_high | (phase_oe_r & phase_out_r);
    // A three-state input turns both switches off
    assign upper_on  = ~tie_high & phase_oe_r & phase_out_r;
    assign lower_on  = ~tie_high & phase_oe_r & ~phase_out_r;
endmodule : mss_gate_drv_model
`default_nettype wire

// ==== sim/mss_sequencer_tb.sv ====
// Self-checking bench for the soft-start sequencer
`timescale 1ns/10ps
`default_nettype none
module mss_sequencer_tb;
    import mss_pkg::*;
    logic        clk_sys, reset, dis_n, core_ok, pok;
    logic [7:0]  err, ref_c;
    logic [31:0] cur;
    logic [3:0]  tie, pin, p_out, p_oe, up_on, lo_on;
    logic [2:0]  cnt;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    int          t0, t1, w0, w1, s;
    mss_sequencer u_dut (.clk_sys(clk_sys), .reset(reset), .freq_select_disable_pin(dis_n),
        .phase_pin_in(pin), .error_level(err), .chan_current(cur), .core_in_window(core_ok),
        .phase_out_r(p_out), .phase_oe_r(p_oe), .ref_code_r(ref_c), .power_ok_flag_r(pok),
        .active_count_r(cnt));
    mss_gate_drv_model u_drv (.phase_out_r(p_out), .phase_oe_r(p_oe), .tie_high(tie),
        .pin_level(pin), .upper_on(up_on), .lower_on(lo_on));
    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Hang guard, sized above the whole planned run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : ticks
    // Reset with a given board tie pattern, count latched a few clocks after release
    task automatic do_reset(input logic [3:0] t);
        tie = t;
        reset = 1'b1;
        ticks(12);
        chk("oe in reset", 32'h0, p_oe);
        chk("switches in reset", 32'h0, up_on | lo_on);
        reset = 1'b0;
        ticks(8);
    endtask : do_reset
    // Clock count of the next rising edge of one phase
    task automatic rise(input int i, output int t);
        logic prev;
        prev = 1'b1;
        t = -1;
        for (int k = 0; k < 600 && t < 0; k++) begin
            @(negedge clk_sys);
            if (p_out[i] === 1'b1 && !prev) t = cyc;
            prev = p_out[i];
        end
    endtask : rise
    // High time of phases 0 and 1 over one switching period
    task automatic width(output int a, output int b);
        a = 0;
        b = 0;
        repeat (256) begin
            @(negedge clk_sys);
            a += int'(p_out[0] === 1'b1);
            b += int'(p_out[1] === 1'b1);
        end
    endtask : width
    // Four phases: start-up into the ramp, duty, spacing, balance, supply drop
    task automatic t_start4;
        do_reset(4'h0);
        chk("count 4", 3'd4, cnt);
        s = cyc;
        for (int k = 0; k < 9000 && p_oe === 4'h0; k++) @(negedge clk_sys);
        chk("tristate len", 1, (cyc - s) inside {[8180:8200]});
        chk("clamp oe", 4'hf, p_oe);
        chk("clamp low", 4'h0, p_out);
        chk("lower clamped", 4'hf, lo_on);
        s = cyc;
        for (int k = 0; k < 40000 && p_out === 4'h0; k++) @(negedge clk_sys);
        chk("clamp len", 1, (cyc - s) inside {[38400:38912]});
        chk("ref rising", 1, ref_c > 8'h00);
        err = 8'hff;
        ticks(80 * 256);
        width(w0, w1);
        err = 8'h08;
        width(t0, t1);
        chk("duty follows error", 1, t0 < w0);
        rise(0, t0);
        rise(1, t1);
        chk("phase spacing", 1, (t1 - t0) inside {64, 192});
        err = 8'h30;
        cur = {8'h40, 8'h40, 8'h40, 8'hc0};
        ticks(256);
        width(w0, w1);
        chk("hot phase shorter", 1, w0 < w1);
        chk("ok held off", 1'b0, pok);
        reset = 1'b1;
        ticks(1);
        chk("oe after drop", 4'h0, p_oe);
        chk("switches after drop", 4'h0, up_on | lo_on);
    endtask : t_start4
    // Three phases, tie removed after capture
    task automatic t_three;
        do_reset(4'h8);
        chk("count 3", 3'd3, cnt);
        tie = 4'h0;
        ticks(8300);
        chk("count kept", 3'd3, cnt);
        chk("three driven", 4'h7, p_oe);
    endtask : t_three
    // Two phases, then the disable pin
    task automatic t_two;
        do_reset(4'hc);
        chk("count 2", 3'd2, cnt);
        ticks(8300);
        chk("two driven", 4'h3, p_oe);
        dis_n = 1'b0;
        ticks(6);
        chk("disabled oe", 4'h0, p_oe);
        dis_n = 1'b1;
    endtask : t_two
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        reset = 1'b1;
        dis_n = 1'b1;
        core_ok = 1'b1;
        err = 8'h80;
        cur = {4{8'h40}};
        tie = 4'h0;
        t_start4();
        t_three();
        t_two();
        complete_run();
    end
endmodule : mss_sequencer_tb
`default_nettype wire
